// [logic/mpc_regs.svh]
// Field positions, reset value and fixed decode pattern of the parity control block
`ifndef MPC_REGS_SVH
`define MPC_REGS_SVH
`define MPC_ADDR_FIXED      12'o7721
`define MPC_BIT_REPORT_EN   0
`define MPC_BIT_FORCE_BAD   2
`define MPC_BIT_ERR_FLAG    15
`define MPC_RESET_VALUE     16'h0000
`define MPC_LOW_PAR_BIT     16
`define MPC_HIGH_PAR_BIT    17
`endif

// [logic/mpc_pkg.sv]
// Types shared by the parity control block
package mpc_pkg;
    typedef struct packed {
        logic        report_en;
        logic        force_bad;
        logic        err_flag;
    } mpc_flags_t;
    typedef struct packed {
        logic [17:0] addr;
        logic [15:0] wdata;
        logic        write;
        logic        read;
    } mpc_bus_req_t;
endpackage

// [logic/mpc_byte_parity.sv]
// One byte parity generator with transparent hold latch and even-parity checker
module mpc_byte_parity (
    input  wire logic       i_sys_clk,
    input  wire logic       i_reset,
    input  wire logic [7:0] i_wr_byte,
    input  wire logic       i_force_bad,
    input  wire logic       i_hold,
    input  wire logic [8:0] i_rd_group,
    output logic            o_par_bit,
    output logic            o_bad
);
    logic gen_d;
    logic par_q;
    // [R7] Odd when forced
    assign gen_d = (^i_wr_byte) ^ i_force_bad;
    // [R10] Follows until held
    assign o_par_bit = i_hold ? par_q : gen_d;
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            par_q <= 1'b0;
        end else if (!i_hold) begin
            par_q <= gen_d;
        end
    end
    // [R11] Odd count is bad
    assign o_bad = ^i_rd_group;
    // [R10] Held bit stays put
    a_latch_holds: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [R10]
        (i_hold && $past(i_hold) && !$past(i_reset)) |-> $stable(o_par_bit))
        else $error("held bit moved");
endmodule // mpc_byte_parity

// [logic/mpc_parity_ctrl.sv]
// Parity control register, decoder, generator and checker
`include "mpc_regs.svh"
// Contract
// [R1] Address bits 17:06 match fixed block
// [R2] Bits 04:02 equal start address 17:15
// [R3] Bit 01 matches address strap
// [R4] Access only with sync, strap removed
// [R5] Decoded access asserts slave acknowledge
// [R6] Bit 00 report enable read/write
// [R7] Bit 02 forces odd stored parity
// [R8] Bit 15 set on error, writable
// [R9] Parity bits 16 low, 17 high
// [R10] Parity held when latch control high
// [R11] Odd ones in group is bad
// [R12] Only fast-bus captured reads checked
// [R13] Flag set when cycle done
// [R14] Report enable gates processor indication
// [R15] Indication needs request and control-valid
// [R16] Processor samples at control-valid drop
// [R17] Processor traps on valid error
// [R18] Write strobe loads, read drives flags
// [R19] Full-word accesses only
// [R20] Other bits read zero
module mpc_parity_ctrl
    import mpc_pkg::*;
(
    input  wire logic        i_sys_clk,
    input  wire logic        i_reset,
    input  wire logic [17:0] i_bus_addr,
    input  wire logic [15:0] i_bus_wdata,
    input  wire logic        i_bus_write,
    input  wire logic        i_bus_read,
    input  wire logic        i_bus_byte,
    input  wire logic        i_master_sync_buffered,
    input  wire logic [2:0]  i_start_address_select,
    input  wire logic        i_addr_strap_in,
    input  wire logic        i_parity_strap_in,
    input  wire logic [15:0] i_mem_wdata,
    input  wire logic        i_byte_write_cycle,
    input  wire logic        i_byte_high,
    input  wire logic        i_write_data_latch_hold,
    input  wire logic [17:0] i_mem_rdata,
    input  wire logic        i_read_data_capture_enable,
    input  wire logic        i_cycle_done,
    input  wire logic        i_processor_request,
    input  wire logic        i_control_valid,
    output logic [15:0]      o_bus_rdata,
    output logic             o_slave_sync_ack,
    output logic [1:0]       o_par_bits,
    output logic [1:0]       o_par_bits_we,
    output logic             o_cpu_parity_error_ind,
    output logic             o_parity_error_flag
);
    // ==================================================
    // Address decode
    logic        hit;
    logic        flag_register_write_strobe;
    logic        flag_register_read_gate;
    mpc_flags_t  flags_q;
    mpc_flags_t  flags_d;
    logic [17:0] rd_q;
    logic        done_q;
    logic        low_byte_bad;
    logic        high_byte_bad;
    logic        bad_parity_any;
    logic        error_flag_set_pulse;
    logic        parity_report_strobe;
    logic [1:0]  par_bits;
    logic [1:0]  byte_bad;
    // [R1] Fixed block match
    // [R2] Start address compare
    // [R3] Strap bit compare
    // [R4] Sync and strap gating
    // [R19] No byte access
    assign hit = (i_bus_addr[17:6] == `MPC_ADDR_FIXED)
               && (i_bus_addr[4:2] == i_start_address_select)
               && (i_bus_addr[1] == !i_addr_strap_in)
               && i_master_sync_buffered && !i_parity_strap_in && !i_bus_byte;
    // [R18] Write strobe and read gate
    assign flag_register_write_strobe = hit && i_bus_write;
    assign flag_register_read_gate    = hit && i_bus_read;
    // ==================================================
    // Read capture and checker
    // [R12] Only captured fast-bus data
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            rd_q   <= 18'h00000;
            done_q <= 1'b0;
        end else begin
            if (i_read_data_capture_enable) begin
                rd_q <= i_mem_rdata;
            end
            done_q <= i_cycle_done;
        end
    end
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_byte
            mpc_byte_parity u_par (
                .i_sys_clk   (i_sys_clk),
                .i_reset     (i_reset),
                .i_wr_byte   (i_mem_wdata[8*g +: 8]),
                .i_force_bad (flags_q.force_bad),
                .i_hold      (i_write_data_latch_hold),
                .i_rd_group  ({rd_q[`MPC_LOW_PAR_BIT + g], rd_q[8*g +: 8]}),
                .o_par_bit   (par_bits[g]),
                .o_bad       (byte_bad[g])
            );
        end
    endgenerate
    // One checker per byte, no second copy to drift
    assign low_byte_bad   = byte_bad[0];
    assign high_byte_bad  = byte_bad[1];
    assign bad_parity_any = low_byte_bad || high_byte_bad;
    // [R13] Set at cycle done
    assign error_flag_set_pulse = bad_parity_any && i_cycle_done && !done_q
                                && !i_parity_strap_in;
    // [R15] Request and control-valid
    assign parity_report_strobe = i_processor_request && i_control_valid;
    // ==================================================
    // Flag register
    always_comb begin
        flags_d = flags_q;
        // [R6] Report enable load
        // [R20] Other bits ignored
        if (flag_register_write_strobe) begin
            flags_d.report_en = i_bus_wdata[`MPC_BIT_REPORT_EN];
            flags_d.force_bad = i_bus_wdata[`MPC_BIT_FORCE_BAD];
            flags_d.err_flag  = i_bus_wdata[`MPC_BIT_ERR_FLAG];
        end
        // [R8] Set wins over write
        if (error_flag_set_pulse) begin
            flags_d.err_flag = 1'b1;
        end
    end
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            flags_q <= '0;
        end else begin
            flags_q <= flags_d;
        end
    end
    // ==================================================
    // Outputs
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_bus_rdata            <= `MPC_RESET_VALUE;
            o_slave_sync_ack       <= 1'b0;
            o_par_bits             <= 2'h0;
            o_par_bits_we          <= 2'h0;
            o_cpu_parity_error_ind <= 1'b0;
            o_parity_error_flag    <= 1'b0;
        end else begin
            // [R6] Flags onto read data
            o_bus_rdata <= flag_register_read_gate
                ? {flags_q.err_flag, 12'h000, flags_q.force_bad, 1'b0, flags_q.report_en}
                : 16'h0000;
            // [R5] Acknowledge any decoded access
            o_slave_sync_ack <= hit && (i_bus_read || i_bus_write);
            // [R9] Bit 16 low, 17 high
            o_par_bits    <= par_bits;
            o_par_bits_we <= i_byte_write_cycle ? {i_byte_high, !i_byte_high} : 2'h3;
            // [R14] Gated by report enable
            o_cpu_parity_error_ind <= parity_report_strobe && flags_q.report_en
                                    && bad_parity_any && !i_parity_strap_in;
            o_parity_error_flag <= flags_q.err_flag;
        end
    end
    // ==================================================
    // Checks
    // Edge seen independently of the done register
    sequence s_bad_at_done;
        bad_parity_any && $rose(i_cycle_done) && !i_parity_strap_in;
    endsequence
    sequence s_flag_shown;
        ##1 o_parity_error_flag;
    endsequence
    sequence s_cpu_sees_bad;
        i_processor_request && i_control_valid && flags_q.report_en
            && bad_parity_any && !i_parity_strap_in;
    endsequence
    // [R5] Ack follows decode
    a_ack_on_hit: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [R5]
        (hit && (i_bus_write || i_bus_read)) |=> o_slave_sync_ack) else $error("no ack");
    // [R4] Strap blocks ack
    a_strap_blocks: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [R4]
        i_parity_strap_in |=> !o_slave_sync_ack) else $error("ack with strap");
    // [R8] Error sets flag
    a_flag_set: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [R8]
        error_flag_set_pulse |=> ##1 o_parity_error_flag) else $error("flag unset");
    // [R14] Disabled report silent
    a_report_gate: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [R14]
        !flags_q.report_en |=> !o_cpu_parity_error_ind) else $error("report leaked");
    // [R15] Strobe required
    a_strobe_gate: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [R15]
        !i_control_valid |=> !o_cpu_parity_error_ind) else $error("no strobe");
    // [R20] Unused bits zero
    a_zero_bits: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [R20]
        o_bus_rdata[14:3] == 12'h000 && !o_bus_rdata[1]) else $error("bits nonzero");
    // [R6] Write then enable register holds bit 00
    a_enable_wr: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [R6]
        (flag_register_write_strobe && !error_flag_set_pulse)
        |=> flags_q.report_en == $past(i_bus_wdata[0])) else $error("enable bad");
    // [R9] Word write both bits
    a_word_we: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [R9]
        !i_byte_write_cycle |=> o_par_bits_we == 2'h3) else $error("word we");
    // [R19] Byte access refused
    a_byte_refused: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [R19]
        i_bus_byte |=> !o_slave_sync_ack) else $error("byte ack");
    // [R4] Sync required
    a_sync_needed: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [R4]
        !i_master_sync_buffered |=> !o_slave_sync_ack) else $error("ack without sync");
    // [R4] Strap freezes flags
    a_strap_freezes: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [R4]
        i_parity_strap_in |=> $stable(flags_q)) else $error("flags moved");
    // [R13] Flag after done edge
    a_done_sets_flag: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [R13]
        s_bad_at_done |=> s_flag_shown) else $error("flag missed");
    // [R14] Enabled error reported
    a_report_raise: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [R14]
        s_cpu_sees_bad |=> o_cpu_parity_error_ind) else $error("report missed");
    // [R18] Read drives flags
    a_read_flags: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [R18]
        flag_register_read_gate |=> o_bus_rdata[15] == $past(flags_q.err_flag)
            && o_bus_rdata[2] == $past(flags_q.force_bad)
            && o_bus_rdata[0] == $past(flags_q.report_en)) else $error("read flags");
    // [R18] Idle read data zero
    a_idle_zero: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [R18]
        !flag_register_read_gate |=> o_bus_rdata == 16'h0000) else $error("idle data");
    // [R12] Uncaptured data ignored
    a_capture_only: assert property (@(posedge i_sys_clk) disable iff (i_reset) // [R12]
        !i_read_data_capture_enable |=> $stable(rd_q)) else $error("capture leak");
endmodule // mpc_parity_ctrl

// [dv/mpc_cpu_model.sv]
// Processor model: one fast-bus read strobe, samples the error line at its end
module mpc_cpu_model #(
    parameter logic [8:0] TRAP_VEC = 9'o114
) (
    input  wire logic       i_sys_clk,
    input  wire logic       i_start,
    input  wire logic [3:0] i_len,
    input  wire logic       i_ind,
    output logic            o_processor_request,
    output logic            o_control_valid,
    output logic            o_trapped,
    output logic [8:0]      o_vector
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_q  = 4'h0;
    logic       req_q  = 1'b0;
    logic       cv_q   = 1'b0;
    logic       trap_q = 1'b0;
    logic [8:0] vec_q  = 9'h000;
    assign o_processor_request = req_q;
    assign o_control_valid     = cv_q;
    assign o_trapped           = trap_q;
    assign o_vector            = vec_q;
    always @(posedge i_sys_clk) begin
        if (i_start && !cv_q) begin
            req_q  <= 1'b1;
            cv_q   <= 1'b1;
            cnt_q  <= i_len;
            trap_q <= 1'b0;
        end else if (cv_q && cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
        end else if (cv_q) begin
            cv_q  <= 1'b0;
            req_q <= 1'b0;
            // Early glitches ignored, sample at drop
            trap_q <= i_ind;
            vec_q <= i_ind ? TRAP_VEC : 9'h000;
        end
    end
endmodule // mpc_cpu_model

// [dv/memory_parity_control_tb.sv]
// Self-checking bench for the parity control block
module memory_parity_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ====================
    // Signals
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, byt = 1'b0, syn = 1'b1;
    logic ast = 1'b1, pst = 1'b0, bw = 1'b0, bh = 1'b0, hold = 1'b0, cap = 1'b0;
    logic done = 1'b0, go = 1'b0, ack, ind, flag, req, cv, trap;
    logic [17:0] addr = 18'h0, mrd = 18'h0;
    logic [15:0] wd = 16'h0, mwd = 16'h0, rdat;
    logic [1:0]  pb, pwe;
    logic [8:0]  vec;
    int n_errors = 0;
    int num_checks = 0;
    // Strap present, so address bit 01 is zero
    localparam logic [17:0] RA = {12'o7721, 1'b0, 3'h5, 2'b00};
    always #2 clk = ~clk;
    mpc_parity_ctrl mpc_parity_ctrl_inst (.i_sys_clk(clk), .i_reset(rst), .i_bus_addr(addr),
        .i_bus_wdata(wd), .i_bus_write(wr), .i_bus_read(rd), .i_bus_byte(byt),
        .i_master_sync_buffered(syn), .i_start_address_select(3'h5), .i_addr_strap_in(ast),
        .i_parity_strap_in(pst), .i_mem_wdata(mwd), .i_byte_write_cycle(bw),
        .i_byte_high(bh), .i_write_data_latch_hold(hold), .i_mem_rdata(mrd),
        .i_read_data_capture_enable(cap), .i_cycle_done(done), .i_processor_request(req),
        .i_control_valid(cv), .o_bus_rdata(rdat), .o_slave_sync_ack(ack), .o_par_bits(pb),
        .o_par_bits_we(pwe), .o_cpu_parity_error_ind(ind), .o_parity_error_flag(flag));
    mpc_cpu_model mpc_cpu_model_inst (.i_sys_clk(clk), .i_start(go), .i_len(4'h3),
        .i_ind(ind), .o_processor_request(req), .o_control_valid(cv), .o_trapped(trap),
        .o_vector(vec));
    // ====================
    // Shared tasks
    task automatic chk(input logic [17:0] s, input logic [17:0] e, input string m);
        num_checks++;
        if (s !== e) begin
            n_errors++;
            $display("MISMATCH %0t %s seen %h exp %h", $time, m, s, e);
        end
    endtask
    task automatic acc(input logic [17:0] a, input logic w, input logic [15:0] d,
                       output logic [15:0] q, output logic k);
        @(posedge clk);
        addr <= a;
        wr <= w;
        rd <= !w;
        wd <= d;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1 q = rdat;
        k = ack;
    endtask
    task automatic gw(input logic [15:0] d, input logic b, input logic h, input logic fb);
        logic [1:0] e;
        e = b ? (h ? 2'b10 : 2'b01) : 2'b11;
        @(posedge clk);
        mwd <= d;
        bw <= b;
        bh <= h;
        repeat (2) @(posedge clk);
        #1 chk(pwe, e, "parity write mask");
        for (int j = 0; j < 2; j++)
            if (e[j]) chk(pb[j], (^d[8*j +: 8]) ^ fb, "parity bit");
    endtask
    task automatic cpu(input logic e);
        @(posedge clk);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (6) @(posedge clk);
        #1 chk(trap, e, "trap taken");
        chk(vec, e ? 9'o114 : 9'h0, "trap vector");
    endtask
    // ====================
    // Scenarios
    task automatic t_reg;
        logic [15:0] q;
        logic k;
        acc(RA, 1'b0, 16'h0, q, k);
        chk(q, 16'h0, "reset value");
        chk(k, 1'b1, "read ack");
        acc(RA, 1'b1, 16'hffff, q, k);
        chk(k, 1'b1, "write ack");
        acc(RA, 1'b0, 16'h0, q, k);
        chk(q, 16'h8005, "only three bits stick");
        chk(flag, 1'b1, "flag copy");
        acc(RA, 1'b1, 16'h0004, q, k);
        acc(RA, 1'b0, 16'h0, q, k);
        chk(q, 16'h0004, "rewrite");
        $display("t_reg done");
    endtask
    task automatic t_decode;
        logic [15:0] q;
        logic k;
        logic [17:0] bad [4] = '{18'h2, 18'h4, 18'h40, 18'h20000};
        for (int i = 0; i < 7; i++) begin
            @(posedge clk);
            byt <= (i == 4);
            syn <= (i != 5);
            pst <= (i == 6);
            acc(i < 4 ? RA ^ bad[i % 4] : RA, 1'b1, 16'h0001, q, k);
            chk(k, 1'b0, "refused ack");
        end
        @(posedge clk);
        byt <= 1'b0;
        syn <= 1'b1;
        pst <= 1'b0;
        ast <= 1'b0;
        acc(RA | 18'h2, 1'b0, 16'h0, q, k);
        chk(q, 16'h0004, "strap removed, bit 01 set");
        @(posedge clk);
        ast <= 1'b1;
        $display("t_decode done");
    endtask
    task automatic t_gen;
        logic [15:0] q;
        logic k;
        gw(16'h0301, 1'b0, 1'b0, 1'b1);
        @(posedge clk);
        hold <= 1'b1;
        @(posedge clk);
        mwd <= 16'h0300;
        repeat (2) @(posedge clk);
        #1 chk(pb, 2'b10, "held parity");
        @(posedge clk);
        hold <= 1'b0;
        acc(RA, 1'b1, 16'h0, q, k);
        gw(16'h0700, 1'b1, 1'b1, 1'b0);
        gw(16'h0007, 1'b1, 1'b0, 1'b0);
        $display("t_gen done");
    endtask
    task automatic t_check;
        logic [15:0] q;
        logic k;
        @(posedge clk);
        cap <= 1'b1;
        @(posedge clk);
        cap <= 1'b0;
        mrd <= 18'h00001;
        @(posedge clk);
        done <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk(flag, 1'b0, "uncaptured read");
        @(posedge clk);
        done <= 1'b0;
        cap <= 1'b1;
        mrd <= 18'h00100;
        repeat (2) @(posedge clk);
        #1 chk(flag, 1'b0, "flag before done");
        @(posedge clk);
        done <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk(flag, 1'b1, "bad high byte");
        acc(RA, 1'b1, 16'h0001, q, k);
        repeat (2) @(posedge clk);
        #1 chk(ind, 1'b0, "no processor strobe");
        cpu(1'b1);
        @(posedge clk);
        mrd <= 18'h20100;
        cpu(1'b0);
        acc(RA, 1'b1, 16'h0, q, k);
        @(posedge clk);
        mrd <= 18'h00100;
        cpu(1'b0);
        @(posedge clk);
        done <= 1'b0;
        pst <= 1'b1;
        @(posedge clk);
        done <= 1'b1;
        repeat (3) @(posedge clk);
        #1 chk(flag, 1'b0, "strap blocks flag");
        @(posedge clk);
        pst <= 1'b0;
        $display("t_check done");
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_reg;
        t_decode;
        t_gen;
        t_check;
        tally_and_finish;
    end
    // Watchdog well beyond the roughly 115 cycles the tests need
    initial begin
        #5000;
        n_errors++;
        tally_and_finish;
    end
endmodule // memory_parity_control_tb
